// ===== lsjd_defs.vh
// constants for the logic, string and jump decoder
// Function
// - exclusive-or decodes as 001100dw, 1000000w with reg 110, or 0011010w.
// - single string_move is 1010010w, 14 cycles, width bit picks byte or word.
// - single string_compare is 1010011w, 22 cycles.
// - single string_scan is 1010111w, 15 cycles.
// - single string_load is 1010110w, result into accumulator, 12 cycles.
// - single string_store is 1010101w, data from accumulator, 10 cycles.
// - single port_string_input is 0110110w, port from port pointer, 14 cycles.
// - single port_string_output is 0110111w, port from port pointer, 14 cycles.
// - repeat_prefix uses count_register; 11110010 plain, 1111001z conditional for compare/scan.
// - repeated costs: move 8+8n, compare 5+22n, scan 5+15n.
// - repeated costs: load 6+11n, store 6+9n, input and output 8+8n.
// - jumps: EB short, E9 near, EA far at 14; FF reg 100 near, 101 far indirect.
// - narrow-bus variant adds 4 cycles per word memory transfer on starred counts.
`ifndef LSJD_DEFS_VH
`define LSJD_DEFS_VH
// ==========================================
// opcodes
`define LSJD_OP_XOR_RM 6'b001100
`define LSJD_OP_IMM_GRP 7'b1000000
`define LSJD_OP_XOR_ACC 7'b0011010
`define LSJD_OP_SMOVE 7'b1010010
`define LSJD_OP_SCMP 7'b1010011
`define LSJD_OP_SSCAN 7'b1010111
`define LSJD_OP_SLOAD 7'b1010110
`define LSJD_OP_SSTORE 7'b1010101
`define LSJD_OP_PIN 7'b0110110
`define LSJD_OP_POUT 7'b0110111
`define LSJD_OP_REP 8'hf2
`define LSJD_OP_REPZ 8'hf3
`define LSJD_OP_JSHORT 8'heb
`define LSJD_OP_JNEAR 8'he9
`define LSJD_OP_JFAR 8'hea
`define LSJD_OP_GRP5 8'hff
`define LSJD_REG_XOR 3'b110
`define LSJD_REG_JIND 3'b100
`define LSJD_REG_JFIND 3'b101
// ==========================================
// cycle counts
`define LSJD_CYC_XOR_RM_R 8'h03
`define LSJD_CYC_XOR_RM_M 8'h0a
`define LSJD_CYC_XOR_IMM_R 8'h04
`define LSJD_CYC_XOR_IMM_M 8'h10
`define LSJD_CYC_XOR_ACC_B 8'h03
`define LSJD_CYC_XOR_ACC_W 8'h04
`define LSJD_CYC_SMOVE 8'h0e
`define LSJD_CYC_SCMP 8'h16
`define LSJD_CYC_SSCAN 8'h0f
`define LSJD_CYC_SLOAD 8'h0c
`define LSJD_CYC_SSTORE 8'h0a
`define LSJD_CYC_PORT 8'h0e
`define LSJD_CYC_JMP 8'h0e
`define LSJD_CYC_JIND_R 8'h0b
`define LSJD_CYC_JIND_M 8'h11
`define LSJD_CYC_JIND_M_N 8'h15
`define LSJD_CYC_JFIND 8'h1a
`define LSJD_CYC_JFIND_N 8'h22
`define LSJD_CYC_WORD_ADD 8'h04
`define LSJD_BASE_MOVE 8'h08
`define LSJD_BASE_CMP 8'h05
`define LSJD_BASE_LOAD 8'h06
`define LSJD_PER_MOVE 8'h08
`define LSJD_PER_LOAD 8'h0b
`define LSJD_PER_STORE 8'h09
// ==========================================
// operation classes
`define LSJD_CL_NONE 4'h0
`define LSJD_CL_XOR 4'h1
`define LSJD_CL_SMOVE 4'h2
`define LSJD_CL_SCMP 4'h3
`define LSJD_CL_SSCAN 4'h4
`define LSJD_CL_SLOAD 4'h5
`define LSJD_CL_SSTORE 4'h6
`define LSJD_CL_PIN 4'h7
`define LSJD_CL_POUT 4'h8
`define LSJD_CL_JMP 4'h9
`endif

// ===== lsjd_classify.v
// combinational classification of one opcode byte plus addressing byte
`default_nettype none
`include "lsjd_defs.vh"
module lsjd_classify (
    // instruction bytes
    input wire [7:0] op,
    input wire [7:0] modrm,
    // result
    output reg [3:0] op_class,
    output reg needs_modrm,
    output reg is_far,
    output reg is_indirect
);
    always @* begin
        op_class = `LSJD_CL_NONE;
        needs_modrm = 1'b0;
        is_far = 1'b0;
        is_indirect = 1'b0;
        if (op[7:2] == `LSJD_OP_XOR_RM) begin
            op_class = `LSJD_CL_XOR;
            needs_modrm = 1'b1;
        end else if (op[7:1] == `LSJD_OP_IMM_GRP && modrm[5:3] == `LSJD_REG_XOR) begin
            op_class = `LSJD_CL_XOR;
            needs_modrm = 1'b1;
        end else if (op[7:1] == `LSJD_OP_XOR_ACC) begin
            op_class = `LSJD_CL_XOR;
        end else begin
            case (op[7:1])
                `LSJD_OP_SMOVE: op_class = `LSJD_CL_SMOVE;
                `LSJD_OP_SCMP: op_class = `LSJD_CL_SCMP;
                `LSJD_OP_SSCAN: op_class = `LSJD_CL_SSCAN;
                `LSJD_OP_SLOAD: op_class = `LSJD_CL_SLOAD;
                `LSJD_OP_SSTORE: op_class = `LSJD_CL_SSTORE;
                `LSJD_OP_PIN: op_class = `LSJD_CL_PIN;
                `LSJD_OP_POUT: op_class = `LSJD_CL_POUT;
                default: op_class = `LSJD_CL_NONE;
            endcase
            case (op)
                `LSJD_OP_JSHORT, `LSJD_OP_JNEAR: op_class = `LSJD_CL_JMP;
                `LSJD_OP_JFAR: begin
                    op_class = `LSJD_CL_JMP;
                    is_far = 1'b1;
                end
                `LSJD_OP_GRP5: begin
                    // far indirect needs a memory operand
                    if (modrm[5:3] == `LSJD_REG_JIND ||
                        (modrm[5:3] == `LSJD_REG_JFIND && modrm[7:6] != 2'b11)) begin
                        op_class = `LSJD_CL_JMP;
                        needs_modrm = 1'b1;
                        is_indirect = 1'b1;
                        is_far = modrm[3];
                    end
                end
                default: ;
            endcase
        end
    end
endmodule // lsjd_classify
`default_nettype wire

// ===== lsjd_cycles.v
// combinational execution-cycle cost of a classified operation
`default_nettype none
`include "lsjd_defs.vh"
module lsjd_cycles #(
    parameter CW = 24
) (
    // operation
    input wire [3:0] op_class,
    input wire [7:0] op,
    input wire [7:0] modrm,
    input wire is_far,
    input wire is_indirect,
    input wire repeat_prefix,
    input wire [15:0] count,
    input wire narrow_bus,
    // result
    output reg [CW-1:0] cycles
);
    function [CW-1:0] lin;
        input [7:0] base;
        input [7:0] per;
        input [15:0] n;
        begin
            lin = {{(CW-8){1'b0}}, base} + {{(CW-8){1'b0}}, per} * {{(CW-16){1'b0}}, n};
        end
    endfunction

    // widen a fixed 8-bit cost to the counter width
    function [CW-1:0] ext8;
        input [7:0] v;
        begin
            ext8 = {{(CW-8){1'b0}}, v};
        end
    endfunction

    wire mem_op = modrm[7:6] != 2'b11;
    wire word_op = op[0];
    reg [7:0] add;

    always @* begin
        cycles = {CW{1'b0}};
        add = 8'h00;
        // narrow bus: extra cost per word memory element, starred rows only
        if (narrow_bus && word_op) add = `LSJD_CYC_WORD_ADD;
        case (op_class)
            `LSJD_CL_XOR: begin
                if (op[7:1] == `LSJD_OP_XOR_ACC)
                    cycles = ext8(word_op ? `LSJD_CYC_XOR_ACC_W : `LSJD_CYC_XOR_ACC_B);
                else if (op[7:2] == `LSJD_OP_XOR_RM)
                    cycles = ext8(mem_op ? `LSJD_CYC_XOR_RM_M + add
                        : `LSJD_CYC_XOR_RM_R);
                else
                    cycles = ext8(mem_op ? `LSJD_CYC_XOR_IMM_M + add
                        : `LSJD_CYC_XOR_IMM_R);
            end
            `LSJD_CL_SMOVE: cycles = repeat_prefix ? lin(`LSJD_BASE_MOVE, `LSJD_PER_MOVE + add, count)
                : ext8(`LSJD_CYC_SMOVE + add);
            `LSJD_CL_SCMP: cycles = repeat_prefix ? lin(`LSJD_BASE_CMP, `LSJD_CYC_SCMP + add, count)
                : ext8(`LSJD_CYC_SCMP + add);
            `LSJD_CL_SSCAN: cycles = repeat_prefix ? lin(`LSJD_BASE_CMP, `LSJD_CYC_SSCAN + add, count)
                : ext8(`LSJD_CYC_SSCAN + add);
            `LSJD_CL_SLOAD: cycles = repeat_prefix ? lin(`LSJD_BASE_LOAD, `LSJD_PER_LOAD + add, count)
                : ext8(`LSJD_CYC_SLOAD + add);
            `LSJD_CL_SSTORE: cycles = repeat_prefix ? lin(`LSJD_BASE_LOAD, `LSJD_PER_STORE + add, count)
                : ext8(`LSJD_CYC_SSTORE + add);
            // single port forms carry no word add, repeated ones do per element
            `LSJD_CL_PIN, `LSJD_CL_POUT:
                cycles = repeat_prefix ? lin(`LSJD_BASE_MOVE, `LSJD_PER_MOVE + add, count)
                : ext8(`LSJD_CYC_PORT);
            `LSJD_CL_JMP: begin
                if (!is_indirect)
                    cycles = ext8(`LSJD_CYC_JMP);
                else if (is_far)
                    cycles = ext8(narrow_bus ? `LSJD_CYC_JFIND_N : `LSJD_CYC_JFIND);
                else if (!mem_op)
                    cycles = ext8(`LSJD_CYC_JIND_R);
                else
                    cycles = ext8(narrow_bus ? `LSJD_CYC_JIND_M_N : `LSJD_CYC_JIND_M);
            end
            default: cycles = {CW{1'b0}};
        endcase
    end
endmodule // lsjd_cycles
`default_nettype wire

// ===== lsjd_decoder.v
// instruction decoder top: prefix capture, classification, cycle timing
`default_nettype none
`include "lsjd_defs.vh"
module lsjd_decoder #(
    parameter CW = 24
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // from prefetch queue
    input wire byte_valid,
    input wire [7:0] op_byte,
    input wire [7:0] modrm_byte,
    // core state
    input wire [15:0] count_register,
    input wire narrow_bus,
    // to execution unit
    output reg busy,
    output reg op_ready,
    output reg done,
    output reg [3:0] op_class,
    output reg word_op,
    output reg rep_active,
    output reg rep_on_equal,
    output reg uses_modrm,
    output reg jump_far,
    output reg jump_indirect,
    output reg acc_operand,
    output reg port_from_pointer,
    output reg [CW-1:0] cycle_count,
    output reg unknown_op
);
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg state_reg;
    reg rep_pend_reg;
    reg repz_pend_reg;
    reg [CW-1:0] remain_reg;

    wire [3:0] cls;
    wire need_m;
    wire far_w;
    wire ind_w;
    wire [CW-1:0] cyc_w;
    wire is_rep_prefix = op_byte == `LSJD_OP_REP || op_byte == `LSJD_OP_REPZ;
    wire is_string = cls >= `LSJD_CL_SMOVE && cls <= `LSJD_CL_POUT;
    wire cond_string = cls == `LSJD_CL_SCMP || cls == `LSJD_CL_SSCAN;
    // prefix only counts where the opcode is a string operation
    wire rep_eff = rep_pend_reg && is_string;

    lsjd_classify u_cls (
        .op(op_byte),
        .modrm(modrm_byte),
        .op_class(cls),
        .needs_modrm(need_m),
        .is_far(far_w),
        .is_indirect(ind_w)
    );

    lsjd_cycles #(.CW(CW)) u_cyc (
        .op_class(cls),
        .op(op_byte),
        .modrm(modrm_byte),
        .is_far(far_w),
        .is_indirect(ind_w),
        .repeat_prefix(rep_eff),
        .count(count_register),
        .narrow_bus(narrow_bus),
        .cycles(cyc_w)
    );

    // ==========================================
    // sequencing
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            rep_pend_reg <= 1'b0;
            repz_pend_reg <= 1'b0;
            remain_reg <= {CW{1'b0}};
            busy <= 1'b0;
            op_ready <= 1'b0;
            done <= 1'b0;
            op_class <= `LSJD_CL_NONE;
            word_op <= 1'b0;
            rep_active <= 1'b0;
            rep_on_equal <= 1'b0;
            uses_modrm <= 1'b0;
            jump_far <= 1'b0;
            jump_indirect <= 1'b0;
            acc_operand <= 1'b0;
            port_from_pointer <= 1'b0;
            cycle_count <= {CW{1'b0}};
            unknown_op <= 1'b0;
        end else begin
            op_ready <= 1'b0;
            done <= 1'b0;
            unknown_op <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (byte_valid) begin
                        if (is_rep_prefix) begin
                            rep_pend_reg <= 1'b1;
                            repz_pend_reg <= op_byte[0];
                        end else begin
                            rep_pend_reg <= 1'b0;
                            repz_pend_reg <= 1'b0;
                            if (cls == `LSJD_CL_NONE) begin
                                unknown_op <= 1'b1;
                            end else begin
                                op_class <= cls;
                                word_op <= op_byte[0];
                                rep_active <= rep_eff;
                                // termination variant only for compare and scan
                                rep_on_equal <= rep_eff && cond_string && repz_pend_reg;
                                uses_modrm <= need_m;
                                jump_far <= far_w;
                                jump_indirect <= ind_w;
                                acc_operand <= cls == `LSJD_CL_SLOAD ||
                                    cls == `LSJD_CL_SSTORE;
                                port_from_pointer <= cls == `LSJD_CL_PIN ||
                                    cls == `LSJD_CL_POUT;
                                cycle_count <= cyc_w;
                                op_ready <= 1'b1;
                                if (cyc_w <= {{(CW-1){1'b0}}, 1'b1}) begin
                                    // a cost of one cycle or less raises done with op_ready and never goes busy
                                    done <= 1'b1;
                                end else begin
                                    remain_reg <= cyc_w - {{(CW-1){1'b0}}, 1'b1};
                                    busy <= 1'b1;
                                    state_reg <= ST_EXEC;
                                end
                            end
                        end
                    end
                end
                ST_EXEC: begin
                    // cycles counted from the accept edge, done on the last
                    if (remain_reg == {{(CW-1){1'b0}}, 1'b1}) begin
                        done <= 1'b1;
                        busy <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                    remain_reg <= remain_reg - {{(CW-1){1'b0}}, 1'b1};
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // lsjd_decoder
`default_nettype wire

// ===== lsjd_assertions.sv
// assertion checker for the logic, string and jump decoder
`default_nettype none
`include "lsjd_defs.vh"
module lsjd_checker #(
    parameter CW = 24
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // prefetch side
    input wire logic byte_valid,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] modrm_byte,
    input wire logic [15:0] count_register,
    input wire logic narrow_bus,
    // execution side
    input wire logic busy,
    input wire logic op_ready,
    input wire logic done,
    input wire logic [3:0] op_class,
    input wire logic word_op,
    input wire logic rep_active,
    input wire logic rep_on_equal,
    input wire logic uses_modrm,
    input wire logic jump_far,
    input wire logic jump_indirect,
    input wire logic acc_operand,
    input wire logic port_from_pointer,
    input wire logic [CW-1:0] cycle_count,
    input wire logic unknown_op
);
    // ==========================================
    // helpers: prefix seen last, cycles since decode
    wire take = byte_valid && !busy;
    wire is_pre = op_byte[7:1] == 7'b1111001;
    logic pre_reg;
    logic [CW-1:0] elapsed_reg;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_reg <= 1'b0;
            elapsed_reg <= '0;
        end else begin
            if (take) pre_reg <= is_pre;
            elapsed_reg <= op_ready ? CW'(2) : elapsed_reg + 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // properties
    sequence s_single(logic [6:0] code);
        take && !is_pre && !pre_reg && !narrow_bus && op_byte[7:1] == code;
    endsequence
    sequence s_rep_move;
        take && op_byte == `LSJD_OP_REP ##1 take && op_byte == 8'ha4;
    endsequence
    sequence s_rep_cmp;
        take && op_byte == `LSJD_OP_REPZ ##1 take && op_byte[7:1] == `LSJD_OP_SCMP;
    endsequence
    property p_xor_acc;
        take && op_byte[7:1] == `LSJD_OP_XOR_ACC |=> op_ready && op_class == `LSJD_CL_XOR
            && cycle_count == ($past(op_byte[0]) ? 4 : 3);
    endproperty
    property p_move;
        s_single(`LSJD_OP_SMOVE) |=> op_class == `LSJD_CL_SMOVE && cycle_count == 14;
    endproperty
    property p_cmp;
        s_single(`LSJD_OP_SCMP) |=> op_class == `LSJD_CL_SCMP && cycle_count == 22;
    endproperty
    property p_scan;
        s_single(`LSJD_OP_SSCAN) |=> op_class == `LSJD_CL_SSCAN && cycle_count == 15;
    endproperty
    property p_load;
        s_single(`LSJD_OP_SLOAD) |=> acc_operand && cycle_count == 12;
    endproperty
    property p_store;
        s_single(`LSJD_OP_SSTORE) |=> acc_operand && cycle_count == 10;
    endproperty
    property p_port;
        take && !pre_reg && op_byte[7:2] == 6'b011011 |=> port_from_pointer
            && op_class == ($past(op_byte[1]) ? 4'h8 : 4'h7) && cycle_count == 14;
    endproperty
    property p_rep_move;
        s_rep_move |=> rep_active && cycle_count == 24'd8 + 24'd8 * $past(count_register);
    endproperty
    property p_rep_cond;
        s_rep_cmp |=> op_ready && rep_active && rep_on_equal;
    endproperty
    property p_jump;
        take && op_byte[7:2] == 6'b111010 && op_byte[1:0] != 2'b00
            |=> op_class == `LSJD_CL_JMP && !rep_active && cycle_count == 14
            && !uses_modrm && jump_far == ($past(op_byte) == `LSJD_OP_JFAR);
    endproperty
    property p_narrow;
        take && !pre_reg && narrow_bus && op_byte == 8'ha5 |=> cycle_count == 18;
    endproperty
    property p_jind_reg;
        take && op_byte == `LSJD_OP_GRP5 && modrm_byte[7:3] == 5'b11100
            |=> jump_indirect && !jump_far && uses_modrm && cycle_count == 11;
    endproperty
    property p_done_time;
        done && !op_ready |-> elapsed_reg == cycle_count && !busy;
    endproperty
    a_xor_acc: assert property (p_xor_acc) else $error("xor accumulator decode wrong");
    a_move: assert property (p_move) else $error("single move decode wrong");
    a_cmp: assert property (p_cmp) else $error("single compare decode wrong");
    a_scan: assert property (p_scan) else $error("single scan decode wrong");
    a_load: assert property (p_load) else $error("single load decode wrong");
    a_store: assert property (p_store) else $error("single store decode wrong");
    a_port: assert property (p_port) else $error("port string decode wrong");
    a_rep_move: assert property (p_rep_move) else $error("repeated move cost wrong");
    a_rep_cond: assert property (p_rep_cond) else $error("conditional repeat wrong");
    a_jump: assert property (p_jump) else $error("direct jump decode wrong");
    a_narrow: assert property (p_narrow) else $error("word add missing");
    a_jind_reg: assert property (p_jind_reg) else $error("register jump cost wrong");
    a_done_time: assert property (p_done_time) else $error("done at wrong cycle");
endmodule // lsjd_checker
bind lsjd_decoder lsjd_checker #(.CW(CW)) chk_u (.ref_clk(ref_clk), .rst(rst),
    .byte_valid(byte_valid), .op_byte(op_byte), .modrm_byte(modrm_byte),
    .count_register(count_register), .narrow_bus(narrow_bus), .busy(busy),
    .op_ready(op_ready), .done(done), .op_class(op_class), .word_op(word_op),
    .rep_active(rep_active), .rep_on_equal(rep_on_equal), .uses_modrm(uses_modrm),
    .jump_far(jump_far), .jump_indirect(jump_indirect), .acc_operand(acc_operand),
    .port_from_pointer(port_from_pointer), .cycle_count(cycle_count),
    .unknown_op(unknown_op));
`default_nettype wire

// ===== tb_top.sv
// self-checking testbench for the logic, string and jump decoder
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic unk;
        logic [3:0] cl;
        logic [23:0] cyc;
        logic repeat_prefix;
        logic req;
        logic w;
    } lsjd_exp_t;
    logic ref_clk, rst, byte_valid, narrow_bus;
    logic [7:0] op_byte, modrm_byte;
    logic [15:0] count_register;
    logic busy, op_ready, done, word_op, rep_active, rep_on_equal, unknown_op;
    logic [3:0] op_class;
    logic [23:0] cycle_count;
    int errors, cmp_count, seed, i;
    lsjd_exp_t exp_q[$];
    lsjd_exp_t mon_e;
    logic [7:0] base_tab[11] = '{8'h30, 8'h80, 8'h34, 8'ha4, 8'ha6, 8'hae, 8'hac,
        8'haa, 8'h6c, 8'h6e, 8'heb};
    lsjd_decoder #(.CW(24)) dut_u (.ref_clk(ref_clk), .rst(rst), .byte_valid(byte_valid),
        .op_byte(op_byte), .modrm_byte(modrm_byte), .count_register(count_register),
        .narrow_bus(narrow_bus), .busy(busy), .op_ready(op_ready), .done(done),
        .op_class(op_class), .word_op(word_op), .rep_active(rep_active),
        .rep_on_equal(rep_on_equal), .uses_modrm(), .jump_far(), .jump_indirect(),
        .acc_operand(), .port_from_pointer(), .cycle_count(cycle_count),
        .unknown_op(unknown_op));
    always #2.5 ref_clk = ~ref_clk;
    // ==========================================
    // expectation and comparison
    function automatic lsjd_exp_t predict(input logic [7:0] op, input logic [7:0] mr,
            input logic [7:0] pre, input logic [15:0] n, input logic nb);
        lsjd_exp_t e;
        logic [23:0] add, s, b, p;
        logic mem;
        e = '0;
        add = (nb && op[0]) ? 24'h4 : 24'h0;
        mem = mr[7:6] != 2'b11;
        e.w = op[0];
        e.cl = 4'h1;
        if (op[7:2] == 6'b001100) begin
            e.cyc = mem ? 24'ha + add : 24'h3;
        end else if (op[7:1] == 7'b1000000 && mr[5:3] == 3'b110) begin
            e.cyc = mem ? 24'h10 + add : 24'h4;
        end else if (op[7:1] == 7'b0011010) begin
            e.cyc = op[0] ? 24'h4 : 24'h3;
        end else begin
            case (op[7:1])
                7'b1010010: {e.cl, s, b, p} = {4'h2, 24'he, 24'h8, 24'h8};
                7'b1010011: {e.cl, s, b, p} = {4'h3, 24'h16, 24'h5, 24'h16};
                7'b1010111: {e.cl, s, b, p} = {4'h4, 24'hf, 24'h5, 24'hf};
                7'b1010110: {e.cl, s, b, p} = {4'h5, 24'hc, 24'h6, 24'hb};
                7'b1010101: {e.cl, s, b, p} = {4'h6, 24'ha, 24'h6, 24'h9};
                7'b0110110: {e.cl, s, b, p} = {4'h7, 24'he, 24'h8, 24'h8};
                7'b0110111: {e.cl, s, b, p} = {4'h8, 24'he, 24'h8, 24'h8};
                default: e.cl = 4'h0;
            endcase
            if (e.cl != 4'h0) begin
                e.repeat_prefix = pre[7:1] == 7'b1111001;
                e.req = e.repeat_prefix && pre[0];
                // single port forms carry no word add
                e.cyc = e.repeat_prefix ? b + (p + add) * n : s + (op[7:4] == 4'h6 ? 24'h0 : add);
            end else begin
                e.cl = 4'h9;
                e.cyc = 24'he;
                if (op == 8'hff && mr[5:3] == 3'b100) e.cyc = mem ? (nb ? 24'h15 : 24'h11) : 24'hb;
                else if (op == 8'hff && mr[5:3] == 3'b101 && mem) e.cyc = nb ? 24'h22 : 24'h1a;
                else if (op[7:2] != 6'b111010 || op[1:0] == 2'b00) e.unk = 1'b1;
            end
        end
        return e;
    endfunction
    task automatic check(input string name, input logic [23:0] exp_v, input logic [23:0] got_v);
        cmp_count++;
        if (got_v !== exp_v) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp_v, got_v);
        end
    endtask
    always @(posedge ref_clk) begin
        if (!rst && (op_ready === 1'b1 || unknown_op === 1'b1)) begin
            mon_e = exp_q.pop_front();
            check("unknown_op", 24'(mon_e.unk), 24'(unknown_op));
            if (!mon_e.unk) begin
                check("op_class", 24'(mon_e.cl), 24'(op_class));
                check("cycle_count", mon_e.cyc, cycle_count);
                check("rep_active", 24'(mon_e.repeat_prefix), 24'(rep_active));
                if (mon_e.repeat_prefix) check("rep_on_equal", 24'(mon_e.req), 24'(rep_on_equal));
                if (mon_e.cl != 4'h1 && mon_e.cl != 4'h9)
                    check("word_op", 24'(mon_e.w), 24'(word_op));
            end
        end
    end
    // ==========================================
    // stimulus
    task automatic send(input logic [7:0] op, input logic [7:0] mr, input logic [7:0] pre,
            input logic [15:0] n, input logic nb);
        int k;
        exp_q.push_back(predict(op, mr, pre, n, nb));
        @(posedge ref_clk);
        if (pre != 8'h00) begin
            byte_valid <= 1'b1;
            op_byte <= pre;
            @(posedge ref_clk);
        end
        byte_valid <= 1'b1;
        op_byte <= op;
        modrm_byte <= mr;
        count_register <= n;
        narrow_bus <= nb;
        @(posedge ref_clk);
        // junk held while busy must be ignored
        if (!exp_q[$].unk) begin
            op_byte <= 8'($random(seed));
            @(posedge ref_clk);
        end
        byte_valid <= 1'b0;
        k = 0;
        #1;
        while (done !== 1'b1 && unknown_op !== 1'b1 && k < 600) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        if (k >= 600) check("completion", 24'h1, 24'h0);
    endtask
    task automatic conclude;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        logic [7:0] op, mr, pre;
        {ref_clk, rst, byte_valid, narrow_bus, op_byte, modrm_byte, count_register} = '0;
        rst = 1'b1;
        seed = 67;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        send(8'ha4, 8'h00, 8'hf2, 16'h3, 1'b0);
        send(8'ha6, 8'h00, 8'hf3, 16'h0, 1'b0);
        send(8'ha5, 8'h00, 8'h00, 16'h0, 1'b1);
        send(8'hff, 8'he0, 8'h00, 16'h0, 1'b0);
        send(8'hff, 8'h2e, 8'h00, 16'h0, 1'b1);
        send(8'hff, 8'he8, 8'h00, 16'h0, 1'b0);
        send(8'heb, 8'h00, 8'hf2, 16'h0, 1'b0);
        send(8'he9, 8'h00, 8'h00, 16'h0, 1'b0);
        send(8'hea, 8'h00, 8'h00, 16'h0, 1'b0);
        send(8'h90, 8'h00, 8'h00, 16'h0, 1'b0);
        send(8'h80, 8'hc0, 8'h00, 16'h0, 1'b0);
        for (i = 0; i < 44; i++) begin
            r = $random(seed);
            op = base_tab[i % 11] | (i % 11 == 0 ? {6'h0, r[1:0]} : {7'h0, r[0]});
            mr = 8'($random(seed));
            if (i % 11 == 1) mr[5:3] = 3'b110;
            pre = (i % 11 >= 3 && i % 11 <= 9 && r[3]) ? 8'hf2 : 8'h00;
            if (pre != 8'h00 && (i % 11 == 4 || i % 11 == 5)) pre[0] = r[4];
            send(op, mr, pre, {13'h0, r[7:5]}, r[8]);
        end
        check("pending", 24'h0, 24'(exp_q.size()));
        conclude();
    end
    initial begin
        #100000;
        errors++;
        conclude();
    end
endmodule // tb_top
`default_nettype wire
